// ### sac_pkg.sv
package sac_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] POSSEL_OFS = 8'h08;
  localparam logic [7:0] NEGSEL_OFS = 8'h0C;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // control register fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_TM_BIT    = 1;
  localparam int CTRL_BUSY_BIT  = 2;
  localparam int CTRL_DONE_BIT  = 3;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_IEN_BIT   = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // config register fields
  localparam int CFG_LJ_BIT   = 2;
  localparam int CFG_DIV_LSB  = 3;
  localparam logic [7:0] CFG_RESET = 8'hF8;

  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [4:0] NEG_GND   = 5'h1F;
  localparam int SEL_LSB        = 0;
  localparam int STAT_DIFF_BIT  = 0;
  localparam int STAT_TRACK_BIT = 1;

  // start-of-conversion sources
  localparam logic [2:0] START_SW    = 3'h0;
  localparam logic [2:0] START_TMR0  = 3'h1;
  localparam logic [2:0] START_TMR2  = 3'h2;
  localparam logic [2:0] START_TMR1  = 3'h3;
  localparam logic [2:0] START_EXT   = 3'h4;
  localparam logic [2:0] START_TMR3  = 3'h5;

  localparam logic [1:0] TRACK_CLOCKS = 2'h3;

  typedef enum logic [1:0] {
    SAC_IDLE  = 2'b00,
    SAC_TRACK = 2'b01,
    SAC_CONV  = 2'b11
  } sac_state_type;
endpackage

// ### sac_sar.sv
`timescale 1ns/10ps
module sac_sar #(
  parameter int WIDTH = 10
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             cmp_in,
  output logic      [WIDTH-1:0] trial,
  output logic                  done,
  output logic      [WIDTH-1:0] code
);
  generate
    if (WIDTH < 2 || WIDTH > 16) begin : g_bad
      $error("sac_sar: WIDTH must be 2 to 16");
    end
  endgenerate

  typedef struct packed {
    logic             run;
    logic [3:0]       idx;
    logic [WIDTH-1:0] trial;
    logic [WIDTH-1:0] code;
    logic             done;
  } sac_sar_type;

  sac_sar_type st_r;
  sac_sar_type st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      st_nxt.run = 1'b0;
    end else if (start && !st_r.run) begin
      st_nxt.run   = 1'b1;
      st_nxt.idx   = 4'(WIDTH - 1);
      st_nxt.trial = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (st_r.run && tick) begin
      // comparator low means the trial overshot the input
      if (!cmp_in) begin
        st_nxt.trial[st_r.idx] = 1'b0;
      end
      if (st_r.idx == 4'h0) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.code = st_nxt.trial;
      end else begin
        st_nxt.idx                   = st_r.idx - 4'h1;
        st_nxt.trial[st_r.idx - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trial = st_r.trial;
  assign done  = st_r.done;
  assign code  = st_r.code;
endmodule

// ### sac_ctrl.sv
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// What this block does
// - converter runs only while enable bit is 1, else shutdown, no conversions.
// - negative select of ground means single-ended, anything else differential.
// - single-ended result is unsigned 10 bits, full scale 0x03FF or 0xFFC0.
// - single-ended unused result bits read zero in both justifications.
// - justify bit 0 puts result low, 1 puts it high in the pair.
// - differential result is two's complement, most negative 0xFE00 or 0x8000.
// - right-justified differential high bits copy the sign bit.
// - left-justified differential low bits below the result read zero.
// - conversion clock is system clock divided by divider setting plus one.
// - 3-bit start mode picks software, timer 0/1/2/3 or external edge.
// - in software mode writing 1 to busy starts one conversion.
// - in external mode a rising convert-start edge starts a conversion.
// - timers 2/3 use low-byte overflow in 8-bit, high-byte in 16-bit mode.
// - busy reads 1 through the conversion and 0 once it completes.
// - busy falling at the end of a conversion sets done flag and raises interrupt when enabled.
// - result registers hold the new value when done flag reads 1.
// - tracking mode 0 tracks continuously except during a conversion.
// - tracking mode 1 tracks three conversion clocks after each start.
// - tracking mode 1 with external start tracks while input low.
// - no tracking during low-power standby or sleep.
// - negative select code 11111 is ground, giving single-ended mode.
// - divider field sits in bits 7 to 3 of the config register.
module sac_ctrl #(
  parameter int RES_BITS = 10
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        timer0_ovf,
  input  wire logic        timer1_ovf,
  input  wire logic        timer2_low_ovf,
  input  wire logic        timer2_high_ovf,
  input  wire logic        timer2_split8,
  input  wire logic        timer3_low_ovf,
  input  wire logic        timer3_high_ovf,
  input  wire logic        timer3_split8,
  input  wire logic        external_convert_start,
  input  wire logic        low_power_standby,
  input  wire logic        cmp_in,
  output logic      [9:0]  sar_trial,
  output logic             sar_track,
  output logic             sar_powered,
  output logic      [4:0]  positive_input_select,
  output logic      [4:0]  negative_input_select,
  output logic             differential_mode,
  output logic             conv_irq
);
  generate
    if (RES_BITS != 10) begin : g_bad
      $error("sac_ctrl: result formatting serves 10 bits only");
    end
    if (sac_pkg::TRACK_CLOCKS == 2'h0) begin : g_bad_track
      $error("sac_ctrl: tracking period needs at least one clock");
    end
  endgenerate

  typedef struct packed {
    sac_pkg::sac_state_type st;
    logic [4:0]  div_cnt;
    logic [1:0]  trk_cnt;
    logic        ext_prev;
    logic        enable;
    logic        track_mode;
    logic        int_en;
    logic [2:0]  start_mode;
    logic        done;
    logic [4:0]  div;
    logic        left_just;
    logic [4:0]  pos_sel;
    logic [4:0]  neg_sel;
    logic [15:0] result;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
  } sac_ctrl_type;

  sac_ctrl_type s_r;
  sac_ctrl_type s_nxt;

  logic       tick;
  logic       sar_start;
  logic       sar_abort;
  logic       sar_done;
  logic [9:0] sar_code;
  logic       trig;
  logic       ext_rise;
  logic       wr_ctrl;
  logic       busy;
  logic       diff;
  logic       wr_cfg;
  logic       wr_pos;
  logic       wr_neg;
  logic       conv_end;

  // place a raw offset-binary code into the 16-bit result pair
  function automatic logic [15:0] fmt(input logic [9:0] raw,
                                      input logic       dif,
                                      input logic       lj);
    logic [9:0] c;
    c = dif ? {~raw[9], raw[8:0]} : raw;
    if (lj) begin
      fmt = {c, 6'h00};
    end else if (dif) begin
      fmt = {{6{c[9]}}, c};
    end else begin
      fmt = {6'h00, c};
    end
  endfunction

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  sac_sar #(
    .WIDTH (RES_BITS)
  ) u_sar (
    .clock  (clock),
    .rst_b  (rst_b),
    .tick   (tick),
    .start  (sar_start),
    .abort  (sar_abort),
    .cmp_in (cmp_in),
    .trial  (sar_trial),
    .done   (sar_done),
    .code   (sar_code)
  );

  assign busy = (s_r.st != sac_pkg::SAC_IDLE);
  assign diff = (s_r.neg_sel != sac_pkg::NEG_GND);
  assign tick = s_r.enable && (s_r.div_cnt == s_r.div);
  // ext_prev resets low, the pin's idle level, so reset makes no edge
  assign ext_rise = external_convert_start && !s_r.ext_prev;
  assign wr_ctrl = s_r.wr_pend && hit(s_r.addr, sac_pkg::CTRL_OFS);
  assign wr_cfg   = s_r.wr_pend && hit(s_r.addr, sac_pkg::CONFIG_OFS);
  assign wr_pos   = s_r.wr_pend && hit(s_r.addr, sac_pkg::POSSEL_OFS);
  assign wr_neg   = s_r.wr_pend && hit(s_r.addr, sac_pkg::NEGSEL_OFS);
  // flag, result and busy all move on this one edge
  assign conv_end = (s_r.st == sac_pkg::SAC_CONV) && sar_done && s_r.enable;

  // trigger selection; timers 2/3 pick overflow byte by width
  always_comb begin
    unique case (s_r.start_mode)
      sac_pkg::START_SW: begin
        trig = wr_ctrl && hwdata[sac_pkg::CTRL_BUSY_BIT];
      end
      sac_pkg::START_TMR0: begin
        trig = timer0_ovf;
      end
      sac_pkg::START_TMR1: begin
        trig = timer1_ovf;
      end
      sac_pkg::START_TMR2: begin
        trig = timer2_split8 ? timer2_low_ovf : timer2_high_ovf;
      end
      sac_pkg::START_TMR3: begin
        trig = timer3_split8 ? timer3_low_ovf : timer3_high_ovf;
      end
      sac_pkg::START_EXT: begin
        trig = ext_rise;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_nxt     = s_r;
    sar_start = 1'b0;
    // clearing enable drops a running conversion without a flag
    sar_abort = !s_r.enable;
    s_nxt.ext_prev = external_convert_start;

    // divider restarts each period so tick spacing is div+1
    if (!s_r.enable || tick) begin
      s_nxt.div_cnt = 5'h00;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 5'h01;
    end

    unique case (s_r.st)
      sac_pkg::SAC_IDLE: begin
        // external start in low-power mode already tracked while low
        if (s_r.enable && trig) begin
          // restart the divider so the first conversion clock is a full one
          s_nxt.div_cnt = 5'h00;
          // mode bits act from the next start, not the write that carries it
          if (s_r.track_mode && s_r.start_mode != sac_pkg::START_EXT) begin
            s_nxt.st      = sac_pkg::SAC_TRACK;
            s_nxt.trk_cnt = 2'h0;
          end else begin
            s_nxt.st  = sac_pkg::SAC_CONV;
            sar_start = 1'b1;
          end
        end
      end
      sac_pkg::SAC_TRACK: begin
        // counts whole conversion clocks from the restarted divider
        if (tick) begin
          s_nxt.trk_cnt = s_r.trk_cnt + 2'h1;
          if (s_r.trk_cnt == sac_pkg::TRACK_CLOCKS - 2'h1) begin
            s_nxt.st  = sac_pkg::SAC_CONV;
            sar_start = 1'b1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        // new starts are not looked at here
        if (conv_end) begin
          s_nxt.st     = sac_pkg::SAC_IDLE;
          s_nxt.result = fmt(sar_code, diff, s_r.left_just);
        end
      end
      default: begin
        s_nxt.st = sac_pkg::SAC_IDLE;
      end
    endcase
    if (!s_r.enable) begin
      s_nxt.st = sac_pkg::SAC_IDLE;
    end

    // bus address phase
    // hsize is not decoded: every access is one whole word
    s_nxt.wr_pend = 1'b0;
    s_nxt.rd_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.rd_pend = !hwrite;
      s_nxt.addr    = haddr[7:0];
    end

    // bus data phase writes
    if (wr_ctrl) begin
      s_nxt.enable     = hwdata[sac_pkg::CTRL_EN_BIT];
      s_nxt.track_mode = hwdata[sac_pkg::CTRL_TM_BIT];
      s_nxt.int_en     = hwdata[sac_pkg::CTRL_IEN_BIT];
      s_nxt.start_mode = hwdata[sac_pkg::CTRL_MODE_LSB +: 3];
      if (hwdata[sac_pkg::CTRL_DONE_BIT]) begin
        s_nxt.done = 1'b0;
      end
    end
    if (wr_cfg) begin
      s_nxt.div       = hwdata[sac_pkg::CFG_DIV_LSB +: 5];
      s_nxt.left_just = hwdata[sac_pkg::CFG_LJ_BIT];
    end
    if (wr_pos) begin
      s_nxt.pos_sel = hwdata[sac_pkg::SEL_LSB +: 5];
    end
    if (wr_neg) begin
      s_nxt.neg_sel = hwdata[sac_pkg::SEL_LSB +: 5];
    end

    // completion after the clear so a same-cycle event survives
    if (conv_end) begin
      s_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r            <= '0;
      s_r.st         <= sac_pkg::SAC_IDLE;
      s_r.enable     <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_EN_BIT];
      s_r.track_mode <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_TM_BIT];
      s_r.int_en     <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_IEN_BIT];
      s_r.start_mode <= sac_pkg::CTRL_RESET[sac_pkg::CTRL_MODE_LSB +: 3];
      s_r.div        <= sac_pkg::CFG_RESET[sac_pkg::CFG_DIV_LSB +: 5];
      s_r.left_just  <= sac_pkg::CFG_RESET[sac_pkg::CFG_LJ_BIT];
      s_r.pos_sel    <= sac_pkg::SEL_RESET;
      s_r.neg_sel    <= sac_pkg::SEL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // read mux over registered state and the live sar_track; unmapped reads give zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (s_r.rd_pend) begin
      if (hit(s_r.addr, sac_pkg::CTRL_OFS)) begin
        hrdata[sac_pkg::CTRL_EN_BIT]        = s_r.enable;
        hrdata[sac_pkg::CTRL_TM_BIT]        = s_r.track_mode;
        hrdata[sac_pkg::CTRL_BUSY_BIT]      = busy;
        hrdata[sac_pkg::CTRL_DONE_BIT]      = s_r.done;
        hrdata[sac_pkg::CTRL_MODE_LSB +: 3] = s_r.start_mode;
        hrdata[sac_pkg::CTRL_IEN_BIT]       = s_r.int_en;
      end else if (hit(s_r.addr, sac_pkg::CONFIG_OFS)) begin
        hrdata[sac_pkg::CFG_DIV_LSB +: 5] = s_r.div;
        hrdata[sac_pkg::CFG_LJ_BIT]       = s_r.left_just;
      end else if (hit(s_r.addr, sac_pkg::POSSEL_OFS)) begin
        hrdata[sac_pkg::SEL_LSB +: 5] = s_r.pos_sel;
      end else if (hit(s_r.addr, sac_pkg::NEGSEL_OFS)) begin
        hrdata[sac_pkg::SEL_LSB +: 5] = s_r.neg_sel;
      end else if (hit(s_r.addr, sac_pkg::RESULT_OFS)) begin
        hrdata[15:0] = s_r.result;
      end else if (hit(s_r.addr, sac_pkg::STATUS_OFS)) begin
        hrdata[sac_pkg::STAT_DIFF_BIT]  = diff;
        hrdata[sac_pkg::STAT_TRACK_BIT] = sar_track;
      end
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // tracking: idle in mode 0, counted window or low input in mode 1
  always_comb begin
    sar_track = 1'b0;
    if (s_r.enable && !low_power_standby) begin
      if (!s_r.track_mode) begin
        sar_track = !busy;
      end else if (s_r.st == sac_pkg::SAC_TRACK) begin
        sar_track = 1'b1;
      end else if (s_r.start_mode == sac_pkg::START_EXT) begin
        sar_track = !busy && !external_convert_start;
      end
    end
  end

  // irq is a level; it drops only when software clears the flag or the interrupt enable bit
  assign sar_powered           = s_r.enable;
  assign positive_input_select = s_r.pos_sel;
  assign negative_input_select = s_r.neg_sel;
  assign differential_mode     = diff;
  assign conv_irq              = s_r.done && s_r.int_en;
endmodule

// ### sac_ctrl_asserts.sv
`timescale 1ns/10ps
module sac_ctrl_asserts (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        low_power_standby,
  input wire logic [9:0]  sar_trial,
  input wire logic        sar_track,
  input wire logic        sar_powered,
  input wire logic [4:0]  negative_input_select,
  input wire logic        differential_mode,
  input wire logic        conv_irq
);
  logic       wr_r;
  logic [7:0] ofs_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= 1'b0;
      ofs_r <= 8'h00;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      ofs_r <= haddr[7:0];
    end
  end
  // data-phase flags, valid only in the cycle after the address phase
  wire wr_ctrl = wr_r && ofs_r == sac_pkg::CTRL_OFS;
  wire wr_neg  = wr_r && ofs_r == sac_pkg::NEGSEL_OFS;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_BUS: assert property (hreadyout && !hresp) else $error("bus not ready");
  AST_DIFF: assert property (differential_mode == (negative_input_select != 5'h1F))
    else $error("mode mismatch");
  AST_NEG: assert property (wr_neg |=> negative_input_select == $past(hwdata[4:0]))
    else $error("neg select not stored");
  AST_STBY: assert property (low_power_standby |-> !sar_track)
    else $error("tracking in standby");
  // two cycles of slack for the abort to land
  AST_OFF: assert property (!sar_powered [*3] |-> $stable(sar_trial))
    else $error("sar moves while off");
  AST_PWR: assert property (wr_ctrl |=> sar_powered == $past(hwdata[0]))
    else $error("power not enable bit");
  AST_HOLD: assert property (conv_irq && !wr_ctrl |=> conv_irq)
    else $error("irq dropped alone");
  AST_IEN: assert property (wr_ctrl && !hwdata[7] |=> !conv_irq)
    else $error("irq while disabled");
  cover property ($rose(conv_irq));
  cover property (sar_track ##1 !sar_track);
  cover property (wr_neg);
endmodule

// ### sar_adc_control_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module sar_adc_control_tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [6:0]  trg;
  logic        timer2_split8, timer3_split8, low_power_standby;
  logic [9:0]  tgt, sar_trial;
  logic        sar_track, sar_powered, differential_mode, conv_irq;
  logic [4:0]  positive_input_select, negative_input_select;
  int          err_total, compares, cyc;
  wire timer0_ovf = trg[0], timer1_ovf = trg[1], timer2_low_ovf = trg[2];
  wire timer2_high_ovf = trg[3], timer3_low_ovf = trg[4], timer3_high_ovf = trg[5];
  wire external_convert_start = trg[6];
  // comparator stands in for the analog input at level tgt
  wire cmp_in = tgt >= sar_trial;
  sac_ctrl sac_ctrl_i (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (3'h2),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .timer0_ovf             (timer0_ovf),
    .timer1_ovf             (timer1_ovf),
    .timer2_low_ovf         (timer2_low_ovf),
    .timer2_high_ovf        (timer2_high_ovf),
    .timer2_split8          (timer2_split8),
    .timer3_low_ovf         (timer3_low_ovf),
    .timer3_high_ovf        (timer3_high_ovf),
    .timer3_split8          (timer3_split8),
    .external_convert_start (external_convert_start),
    .low_power_standby      (low_power_standby),
    .cmp_in                 (cmp_in),
    .sar_trial              (sar_trial),
    .sar_track              (sar_track),
    .sar_powered            (sar_powered),
    .positive_input_select  (positive_input_select),
    .negative_input_select  (negative_input_select),
    .differential_mode      (differential_mode),
    .conv_irq               (conv_irq)
  );
  always #50 clock = ~clock;
  task summarize;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (!hreadyout);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask
  task automatic conv(input logic [31:0] c, input int k, input logic eb, input int d,
                      input logic [15:0] ex);
    logic [31:0] q;
    logic [9:0]  t;
    int          n;
    int          c0;
    c0 = cyc;
    // a start on the write that sets enable is dropped, so enable first
    wr(sac_pkg::CTRL_OFS, c & ~32'h00000004);
    wr(sac_pkg::CTRL_OFS, c);
    if (k < 7) begin
      @(posedge clock);
      trg <= 7'(1 << k);
      @(posedge clock);
      trg <= 7'h00;
    end
    rd(sac_pkg::CTRL_OFS, q);
    `CHK("busy", eb, q[2])
    if (eb) begin
      for (int j = 0; j < 2; j++) begin
        t = sar_trial;
        n = 0;
        while (sar_trial === t && n < 99) begin
          @(negedge clock);
          n++;
        end
      end
      `CHK("tick gap", d + 1, n)
      `CHK("track", 1'b0, sar_track)
      if (d == 31) wr(sac_pkg::CTRL_OFS, c);
      n = 0;
      q = 32'h00000000;
      while (!q[3] && n < 200) begin
        rd(sac_pkg::CTRL_OFS, q);
        n++;
      end
      // a restart would stretch the run by the ticks already done
      if (d == 31) `CHK("length", 1'b1, cyc - c0 < 345)
      `CHK("busy end", 1'b0, q[2])
      `CHK("irq", c[7], conv_irq)
      rd(sac_pkg::RESULT_OFS, q);
      `CHK("result", {16'h0000, ex}, q)
      wr(sac_pkg::CTRL_OFS, (c & ~32'h00000004) | 32'h00000008);
      rd(sac_pkg::CTRL_OFS, q);
      `CHK("done clear", 1'b0, q[3])
      `CHK("irq clear", 1'b0, conv_irq)
    end
  endtask
  int          lj[7] = '{0, 1, 0, 0, 1, 0, 1};
  logic [9:0]  tg[7] = '{10'h3FF, 10'h3FF, 10'h000, 10'h000, 10'h000, 10'h100, 10'h100};
  logic [15:0] ex[7] = '{16'h03FF, 16'hFFC0, 16'h0000, 16'hFE00, 16'h8000, 16'hFF00, 16'hC000};
  int          md[8] = '{1, 3, 2, 2, 2, 5, 5, 4};
  int          kk[8] = '{0, 1, 2, 3, 3, 4, 5, 6};
  logic        sp[8] = '{0, 0, 1, 0, 1, 1, 0, 0};
  logic        eb[8] = '{1, 1, 1, 1, 0, 1, 1, 1};
  int          dv[3] = '{0, 5, 31};
  logic [31:0] q;
  int          n;
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, trg, tgt} = '0;
    {timer2_split8, timer3_split8, low_power_standby} = '0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(sac_pkg::CTRL_OFS, q);
    `CHK("ctrl reset", 32'h00000000, q)
    rd(sac_pkg::CONFIG_OFS, q);
    `CHK("config reset", 32'h000000F8, q)
    `CHK("diff reset", 1'b1, differential_mode)
    wr(8'h18, 32'h000000FF);
    rd(8'h18, q);
    `CHK("unmapped", 32'h00000000, q)
    wr(sac_pkg::NEGSEL_OFS, 32'h0000001F);
    rd(sac_pkg::NEGSEL_OFS, q);
    `CHK("negsel", 32'h0000001F, q)
    `CHK("single ended", 1'b0, differential_mode)
    wr(sac_pkg::CTRL_OFS, 32'h00000004);
    rd(sac_pkg::CTRL_OFS, q);
    `CHK("off start", 1'b0, q[2])
    `CHK("off power", 1'b0, sar_powered)
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(sac_pkg::NEGSEL_OFS, i < 3 ? 32'h0000001F : 32'h00000000);
      wr(sac_pkg::CONFIG_OFS, 32'(lj[i] << 2));
      tgt <= tg[i];
      conv(32'h00000085, 7, 1'b1, 0, ex[i]);
    end
    $display("test formats done");
    wr(sac_pkg::NEGSEL_OFS, 32'h0000001F);
    wr(sac_pkg::CONFIG_OFS, 32'h00000000);
    tgt <= 10'h155;
    for (int i = 0; i < 8; i++) begin
      timer2_split8 <= sp[i];
      timer3_split8 <= sp[i];
      conv(32'(32'h81 | (md[i] << 4)), kk[i], eb[i], 0, 16'h0155);
    end
    $display("test triggers done");
    for (int i = 0; i < 3; i++) begin
      wr(sac_pkg::CONFIG_OFS, 32'(dv[i] << 3));
      conv(32'h00000005, 7, 1'b1, dv[i], 16'h0155);
    end
    $display("test divider done");
    wr(sac_pkg::CONFIG_OFS, 32'h00000000);
    // track mode is sampled at the start, so it goes in first
    wr(sac_pkg::CTRL_OFS, 32'h00000003);
    wr(sac_pkg::CTRL_OFS, 32'h00000007);
    n = 0;
    repeat (12) begin
      @(negedge clock);
      if (sar_track === 1'b1) n++;
    end
    `CHK("track clocks", 3, n)
    repeat (20) @(posedge clock);
    wr(sac_pkg::CTRL_OFS, 32'h00000043);
    @(negedge clock);
    `CHK("ext low track", 1'b1, sar_track)
    @(posedge clock);
    trg <= 7'h40;
    @(negedge clock);
    `CHK("ext high track", 1'b0, sar_track)
    repeat (15) @(posedge clock);
    trg <= 7'h00;
    wr(sac_pkg::CTRL_OFS, 32'h00000009);
    @(negedge clock);
    `CHK("idle track", 1'b1, sar_track)
    @(posedge clock);
    low_power_standby <= 1'b1;
    @(negedge clock);
    `CHK("standby track", 1'b0, sar_track)
    $display("test tracking done");
    summarize;
  end
endmodule
bind sac_ctrl sac_ctrl_asserts sac_ctrl_asserts_i (
  .clock                 (clock),
  .rst_b                 (rst_b),
  .hsel                  (hsel),
  .haddr                 (haddr),
  .htrans                (htrans),
  .hwrite                (hwrite),
  .hwdata                (hwdata),
  .hready                (hready),
  .hreadyout             (hreadyout),
  .hresp                 (hresp),
  .low_power_standby     (low_power_standby),
  .sar_trial             (sar_trial),
  .sar_track             (sar_track),
  .sar_powered           (sar_powered),
  .negative_input_select (negative_input_select),
  .differential_mode     (differential_mode),
  .conv_irq              (conv_irq)
);
